// file: adc_ctrl_regs.vh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// register byte offsets
`define REG_OUT_DISABLE    9'h014
`define REG_CONFIG         9'h018
`define REG_CLK_DIV        9'h01c
`define REG_STATUS         9'h020
`define REG_IRQ_STATUS     9'h024
`define REG_IRQ_MASK       9'h028
`define REG_SYNC_CTRL      9'h100

// control register fields
`define CFG_PORT_MODE      0
`define CFG_FMT_LO         1
`define CFG_FMT_HI         2
`define CFG_STAB_EN        3
`define CFG_CAPCLK_INV     4
`define CFG_POWER_DOWN     5
`define CFG_STANDBY        6
`define SYNC_EN            1
`define SYNC_ONCE          2
`define OUTDIS_CH_A        0
`define OUTDIS_CH_B        1

// status fields
`define ST_STAB_LOCKED     0
`define ST_STAB_REQ        1
`define ST_POWERED_DOWN    2
`define ST_STANDBY         3
`define ST_SYNC_ARMED      4

// interrupt events
`define EV_SYNC            0
`define EV_OVR_A           1
`define EV_OVR_B           2
`define EV_STAB_LOCK       3
`define EV_BITS            4

// reset values
`define CONFIG_RST         7'h00
`define CLK_DIV_RST        3'h0
`define SYNC_CTRL_RST      2'h0
`define OUT_DISABLE_RST    2'h0
`define IRQ_MASK_RST       4'h0

// output coding
`define FMT_OFFSET         2'h0
`define FMT_TWOS           2'h1
`define FMT_GRAY           2'h2
`define CODE_MSB           10'h200
`define CODE_MAX           10'h3ff
`define CODE_MIN           10'h000

// core value in half lsb steps; limits of the overrange flag and, in lsb, of the saturated code
`define HALF_POS_LIMIT     12'sd1023
`define HALF_NEG_LIMIT     -12'sd1025
`define LSB_POS_MAX        12'sd511
`define LSB_NEG_MIN        -12'sd512

// timing
`define MCLK_HZ            40000000
`define STAB_MIN_HZ        20000000
`define STAB_RELOCK_NS     1500
`define STAB_RELOCK_CYC    ((`STAB_RELOCK_NS * (`MCLK_HZ / 1000000) + 999) / 1000)
`define PIPE_LATENCY       12

`endif

// file: clk_divider.v
// integer sample clock divider with synchronous return to its initial count
module clk_divider (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [2:0] ratio_m1,
  input  wire       resync,
  output reg  [2:0] count,
  output wire       tick
);

  // the first count after a resync is the sampling edge
  assign tick = (count == 3'h0);

  always @(posedge mclk) begin
    if (!rst_n) begin
      count <= 3'h0;
    end else if (resync) begin
      count <= 3'h0;
    end else if (count >= ratio_m1) begin
      count <= 3'h0;
    end else begin
      count <= count + 3'h1;
    end
  end

endmodule // clk_divider

// file: sample_delay_mem.v
// circular store holding raw samples of both channels for the output pipeline
`include "adc_ctrl_regs.vh"

module sample_delay_mem (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        advance,
  input  wire [23:0] wdata,
  output reg  [23:0] rdata
);

  localparam integer LAST_FULL = `PIPE_LATENCY - 2;
  localparam [3:0]   LAST      = LAST_FULL[3:0];

  reg [23:0] mem [0:`PIPE_LATENCY-2];
  reg [3:0]  ptr;

  // the slot read is the one written PIPE_LATENCY-1 advances ago, read before it is overwritten
  always @(posedge mclk) begin
    if (advance) begin
      mem[ptr] <= wdata;
      rdata    <= mem[ptr];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      ptr <= 4'h0;
    end else if (advance) begin
      ptr <= (ptr == LAST) ? 4'h0 : ptr + 4'h1;
    end
  end

endmodule // sample_delay_mem

// file: adc_ctrl.v
// clock divider, duty cycle stabilizer control, power and output control of a dual converter
//
// Local design decisions: the register addresses and the strobed register port.
`include "adc_ctrl_regs.vh"

// Operation
// - divide sample clock by 1 to 8
// - ratio above one forces stabilizer on
// - sync on every pulse or first after write
// - accepted sync restarts divider count
// - stabilizer regenerates falling edge at half period
// - stabilizer inactive below 20 MHz internal rate
// - stabilizer bypassed for 1.5 us after change
// - power down by pin or control bit
// - power down three-states all outputs
// - standby keeps reference, halts conversion
// - straps pick format and stabilizer
// - port selects offset, twos or gray
// - three-state pin high disables data drivers
// - per-channel output disable bit
// - twelve sample clock pipeline latency; here eleven divided periods plus one mclk
// - data valid on data clock rising edge
// - two data clock outputs
// - saturate ten-bit codes, overrange past half lsb
module adc_ctrl (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire [8:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rdata,
  input  wire        power_down_pin,
  input  wire        output_tristate_pin,
  input  wire        format_select_strap,
  input  wire        stabilizer_strap,
  input  wire        sync_in,
  input  wire [11:0] core_a,
  input  wire [11:0] core_b,
  output reg  [9:0]  data_a,
  output reg         overrange_a,
  output reg         data_a_oe,
  output reg  [9:0]  data_b,
  output reg         overrange_b,
  output reg         data_b_oe,
  output reg  [1:0]  data_capture_clock_out,
  output reg         capture_clock_oe,
  output reg         internal_clk,
  output reg         irq
);

  localparam integer RELOCK_FULL = `STAB_RELOCK_CYC;
  localparam [6:0]   RELOCK_CYC  = RELOCK_FULL[6:0];

  // control registers
  reg  [6:0]            setup;
  reg  [2:0]            clk_div;
  reg  [1:0]            sync_ctrl;
  reg  [1:0]            out_disable;
  reg  [`EV_BITS-1:0]   irq_status;
  reg  [`EV_BITS-1:0]   irq_mask;

  // internal state
  reg                   sync_armed;
  reg  [6:0]            relock_cnt;
  reg                   stab_locked;
  reg                   stab_req_q;
  reg  [2:0]            clk_div_q;
  reg                   tick_q;
  wire [2:0]            div_count;
  wire                  div_tick;
  wire [23:0]           pipe_q;

  // decoded controls
  wire                  port_mode;
  wire [1:0]            fmt_sel;
  wire                  stab_setting;
  wire                  stab_req;
  wire                  stab_functional;
  wire                  relock_start;
  wire                  powered_down;
  wire                  standby;
  wire                  converting;
  wire                  sync_accept;
  wire                  rd_irq;
  wire [10:0]           next_code_a;
  wire [10:0]           next_code_b;
  wire [`EV_BITS-1:0]   events;
  wire [`EV_BITS-1:0]   next_irq_status;
  reg  [31:0]           next_rdata;
  reg  [2:0]            half_cnt;

  // converts a core value in half lsb steps into coded output plus overrange
  function [10:0] code_out;
    input signed [11:0] h;
    input        [1:0]  f;
    reg   signed [12:0] r;
    reg          [9:0]  ob;
    reg                 ovr;
    begin
      r   = ($signed({h[11], h}) + 13'sd1) >>> 1;
      ovr = (h > `HALF_POS_LIMIT) || (h < `HALF_NEG_LIMIT);
      if (r > `LSB_POS_MAX) begin
        ob = `CODE_MAX;
      end else if (r < `LSB_NEG_MIN) begin
        ob = `CODE_MIN;
      end else begin
        ob = r[9:0] ^ `CODE_MSB;
      end
      case (f)
        `FMT_TWOS: code_out = {ovr, ob ^ `CODE_MSB};
        `FMT_GRAY: code_out = {ovr, ob ^ (ob >> 1)};
        default:   code_out = {ovr, ob};
      endcase
    end
  endfunction

  // straps rule until software claims the port; formats above gray fall back to offset
  assign port_mode       = setup[`CFG_PORT_MODE];
  assign fmt_sel         = port_mode ? setup[`CFG_FMT_HI:`CFG_FMT_LO] :
                           {1'b0, format_select_strap};
  assign stab_setting    = port_mode ? setup[`CFG_STAB_EN] : stabilizer_strap;
  assign stab_req        = stab_setting || (clk_div != 3'h0);
  // internal rate is mclk over the ratio; the loop cannot follow below the floor
  assign stab_functional = ((`MCLK_HZ / `STAB_MIN_HZ) >= ({29'h0, clk_div} + 32'h1));
  assign relock_start    = (clk_div != clk_div_q) || (stab_req && !stab_req_q) ||
                           !stab_req || !stab_functional;
  assign powered_down    = power_down_pin || (port_mode && setup[`CFG_POWER_DOWN]);
  assign standby         = port_mode && setup[`CFG_STANDBY] && !powered_down;
  assign converting     = !powered_down && !standby;
  assign sync_accept    = sync_in && sync_ctrl[0] && (!sync_ctrl[1] || sync_armed);

  clk_divider u_div (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ratio_m1 (clk_div),
    .resync   (sync_accept),
    .count    (div_count),
    .tick     (div_tick)
  );

  // raw core values are stored; coding happens on the way out so format writes act at once
  sample_delay_mem u_pipe (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .advance (div_tick && converting),
    .wdata   ({core_b, core_a}),
    .rdata   (pipe_q)
  );

  assign next_code_a = code_out(pipe_q[11:0], fmt_sel);
  assign next_code_b = code_out(pipe_q[23:12], fmt_sel);

  // register writes
  always @(posedge mclk) begin
    if (!rst_n) begin
      setup       <= `CONFIG_RST;
      clk_div     <= `CLK_DIV_RST;
      sync_ctrl   <= `SYNC_CTRL_RST;
      out_disable <= `OUT_DISABLE_RST;
      irq_mask    <= `IRQ_MASK_RST;
    end else if (wr_en) begin
      case (addr)
        `REG_CONFIG:      setup       <= wdata[6:0];
        `REG_CLK_DIV:     clk_div     <= wdata[2:0];
        `REG_SYNC_CTRL:   sync_ctrl   <= {wdata[`SYNC_ONCE], wdata[`SYNC_EN]};
        `REG_OUT_DISABLE: out_disable <= wdata[1:0];
        `REG_IRQ_MASK:    irq_mask    <= wdata[`EV_BITS-1:0];
        default: ;
      endcase
    end
  end

  // a write to the sync register arms the one-shot; the accepted pulse disarms it
  always @(posedge mclk) begin
    if (!rst_n) begin
      sync_armed <= 1'b0;
    end else if (wr_en && (addr == `REG_SYNC_CTRL)) begin
      sync_armed <= 1'b1;
    end else if (sync_accept) begin
      sync_armed <= 1'b0;
    end
  end

  // any ratio change or new stabilizer request drops lock and restarts the wait
  always @(posedge mclk) begin
    if (!rst_n) begin
      clk_div_q   <= `CLK_DIV_RST;
      stab_req_q  <= 1'b0;
      relock_cnt  <= RELOCK_CYC;
      stab_locked <= 1'b0;
    end else begin
      clk_div_q  <= clk_div;
      stab_req_q <= stab_req;
      if (relock_start) begin
        relock_cnt  <= RELOCK_CYC;
        stab_locked <= 1'b0;
      end else if (relock_cnt != 7'h0) begin
        relock_cnt  <= relock_cnt - 7'h1;
        stab_locked <= 1'b0;
      end else begin
        stab_locked <= 1'b1;
      end
    end
  end

  // locked: high for the first half of the divided period; bypassed: raw one-cycle pulse
  always @* begin
    half_cnt = {1'b0, clk_div[2:1]} + 3'h1;
  end

  // lock gained: the wait has run out and nothing restarts it in this cycle
  assign events = {!relock_start && (relock_cnt == 7'h0) && !stab_locked,
                   tick_q && converting && next_code_b[10],
                   tick_q && converting && next_code_a[10],
                   sync_accept};

  assign rd_irq          = rd_en && (addr == `REG_IRQ_STATUS);
  // a new event wins over the clear by the read in the same cycle
  assign next_irq_status = (rd_irq ? {`EV_BITS{1'b0}} : irq_status) | events;

  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_status <= {`EV_BITS{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // outputs launch one mclk after the divided rising edge, one stage after the store
  always @(posedge mclk) begin
    if (!rst_n) begin
      tick_q                 <= 1'b0;
      data_a                 <= `CODE_MIN;
      data_b                 <= `CODE_MIN;
      overrange_a            <= 1'b0;
      overrange_b            <= 1'b0;
      data_a_oe              <= 1'b0;
      data_b_oe              <= 1'b0;
      capture_clock_oe       <= 1'b0;
      internal_clk           <= 1'b0;
      data_capture_clock_out <= 2'b00;
    end else begin
      tick_q <= div_tick && converting;
      if (tick_q && converting) begin
        data_a      <= next_code_a[9:0];
        overrange_a <= next_code_a[10];
        data_b      <= next_code_b[9:0];
        overrange_b <= next_code_b[10];
      end
      // three-state control is slow by nature; not for sharing a bus between samples
      data_a_oe <= !powered_down && !output_tristate_pin &&
                   !(port_mode && out_disable[`OUTDIS_CH_A]);
      data_b_oe <= !powered_down && !output_tristate_pin &&
                   !(port_mode && out_disable[`OUTDIS_CH_B]);
      capture_clock_oe <= !powered_down;
      if (stab_locked) begin
        internal_clk <= (div_count < half_cnt);
      end else begin
        internal_clk <= div_tick;
      end
      // data change one cycle after the tick, so the data clock rises half_cnt-1 cycles after the data, inverted on request
      data_capture_clock_out <= {2{(div_count >= half_cnt) ^ setup[`CFG_CAPCLK_INV]}};
    end
  end

  // register reads, answered one cycle later
  always @* begin
    next_rdata = 32'h0;
    case (addr)
      `REG_CONFIG:      next_rdata = {25'h0, setup};
      `REG_CLK_DIV:     next_rdata = {29'h0, clk_div};
      `REG_SYNC_CTRL:   next_rdata = {29'h0, sync_ctrl, 1'b0};
      `REG_OUT_DISABLE: next_rdata = {30'h0, out_disable};
      `REG_STATUS:      next_rdata = {27'h0, sync_armed, standby, powered_down,
                                      stab_req, stab_locked};
      `REG_IRQ_STATUS:  next_rdata = {{(32-`EV_BITS){1'b0}}, irq_status};
      `REG_IRQ_MASK:    next_rdata = {{(32-`EV_BITS){1'b0}}, irq_mask};
      default:          next_rdata = 32'h0;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule // adc_ctrl

// file: adc_ctrl_props.sv
// concurrent checks on the converter control ports
module adc_ctrl_props (
  input wire        mclk,
  input wire        rst_n,
  input wire [8:0]  addr,
  input wire        rd_en,
  input wire [31:0] rdata,
  input wire        power_down_pin,
  input wire        output_tristate_pin,
  input wire [9:0]  data_a,
  input wire        overrange_a,
  input wire        data_a_oe,
  input wire [9:0]  data_b,
  input wire        overrange_b,
  input wire        data_b_oe,
  input wire [1:0]  data_capture_clock_out,
  input wire        capture_clock_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // three held cycles cover the one driver register with a cycle to spare
  sequence s_pd_held;
    power_down_pin [*3];
  endsequence
  sequence s_tristate_held;
    output_tristate_pin [*3];
  endsequence
  a_pd_drivers_off: assert property (s_pd_held |-> !data_a_oe && !data_b_oe && !capture_clock_oe)
    else $error("drivers on in power down");
  a_pd_freeze: assert property (s_pd_held ##1 power_down_pin |-> $stable(data_a) && $stable(data_b))
    else $error("data moved in power down");
  a_tristate_data_off: assert property (s_tristate_held |-> !data_a_oe && !data_b_oe)
    else $error("data drivers on with three-state pin high");
  a_capclk_twin: assert property (data_capture_clock_out[0] == data_capture_clock_out[1])
    else $error("data clocks differ");
  a_ovr_a_clip: assert property (overrange_a |-> data_a inside {10'h000, 10'h3ff, 10'h200, 10'h1ff})
    else $error("overrange a without clipped code");
  a_ovr_b_clip: assert property (overrange_b |-> data_b inside {10'h000, 10'h3ff, 10'h200, 10'h1ff})
    else $error("overrange b without clipped code");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (rd_en && addr == 9'h004 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // adc_ctrl_props

bind adc_ctrl adc_ctrl_props adc_ctrl_props_i (.mclk, .rst_n, .addr, .rd_en, .rdata,
  .power_down_pin, .output_tristate_pin, .data_a, .overrange_a, .data_a_oe, .data_b,
  .overrange_b, .data_b_oe, .data_capture_clock_out, .capture_clock_oe);

// file: host_capture.sv
// host side register capturing channel a on the rising data clock
module host_capture (
  input  wire        mclk,
  input  wire        capclk,
  input  wire        capclk_oe,
  input  wire [9:0]  data_a,
  output logic [9:0] cap_a
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'h0;
  // data clock only moves on mclk edges, so sampling it there misses no edge
  always @(posedge mclk) begin
    prev <= capclk;
    if (capclk_oe && capclk && !prev)
      cap_a <= data_a;
  end
endmodule // host_capture

// file: adc_ctrl_tb.sv
// self-checking testbench of the converter control block
`include "adc_ctrl_regs.vh"
module adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, rst_n = 1'h0, wr_en = 1'h0, rd_en = 1'h0, sync_in = 1'h0;
  logic        power_down_pin = 1'h0, output_tristate_pin = 1'h0;
  logic        format_select_strap = 1'h0, stabilizer_strap = 1'h1;
  logic [8:0]  addr = 9'h0;
  logic [31:0] wdata = 32'h0;
  logic [11:0] core_a = 12'h0, core_b = 12'h0;
  wire  [31:0] rdata;
  wire  [9:0]  data_a, data_b, cap_a;
  wire  [1:0]  data_capture_clock_out;
  wire         overrange_a, overrange_b, data_a_oe, data_b_oe, capture_clock_oe, internal_clk, irq;
  int          n_errors = 0, compares = 0, cyc = 0, seed = 84705;
  logic [21:0] hist [$];
  logic [11:0] corner [8] = '{12'h7ff, 12'h800, 12'h3ff, 12'h400, 12'hbff, 12'hbfe, 12'h0, 12'hfff};
  logic [8:0]  rst_regs [6] = '{`REG_OUT_DISABLE, `REG_CONFIG, `REG_CLK_DIV, `REG_IRQ_MASK,
                                `REG_SYNC_CTRL, 9'h004};

  adc_ctrl adc_ctrl_i (.mclk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .power_down_pin,
    .output_tristate_pin, .format_select_strap, .stabilizer_strap, .sync_in, .core_a, .core_b,
    .data_a, .overrange_a, .data_a_oe, .data_b, .overrange_b, .data_b_oe,
    .data_capture_clock_out, .capture_clock_oe, .internal_clk, .irq);
  host_capture host_capture_i (.mclk, .capclk(data_capture_clock_out[0]),
    .capclk_oe(capture_clock_oe), .data_a, .cap_a);

  initial forever #12.5 mclk = ~mclk;

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(logic [8:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge mclk);
    wr_en <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic rdc(logic [8:0] a, logic [31:0] m, logic [31:0] e);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge mclk);
    rd_en <= 1'h0;
    #1;
    chk($sformatf("reg %h", a), e, rdata & m);
    @(posedge mclk);
  endtask

  task automatic oe(logic [2:0] e);
    repeat (3) @(posedge mclk);
    #1;
    chk("enables", {29'h0, e}, {29'h0, data_a_oe, data_b_oe, capture_clock_oe});
    @(posedge mclk);
  endtask

  task automatic irq_is(logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge mclk);
  endtask

  task automatic pulse();
    sync_in <= 1'h1;
    @(posedge mclk);
    sync_in <= 1'h0;
    @(posedge mclk);
  endtask

  // cycles from now to the next rising data clock, ends on an edge
  task automatic next_rise(output int n);
    logic p;
    #1;
    n = 0;
    do begin
      p = data_capture_clock_out[0];
      @(posedge mclk);
      #1;
      n++;
    end while (n < 40 && !(data_capture_clock_out[0] === 1'h1 && p === 1'h0));
    @(posedge mclk);
  endtask

  // overrange flag over the ten-bit code; h counts half lsb steps
  function automatic logic [10:0] code(logic signed [11:0] h, logic [1:0] f);
    logic signed [12:0] r;
    logic [9:0]         o;
    r = ($signed({h[11], h}) + 13'sh1) >>> 1;
    o = (r > 13'sh1ff) ? 10'h3ff : (r < 13'sh1e00) ? 10'h000 : r[9:0] ^ 10'h200;
    if (f == 2'h1)
      o = o ^ 10'h200;
    else if (f == 2'h2)
      o = o ^ (o >> 1);
    return {(h > 12'sh3ff) || (h < 12'shbff), o};
  endfunction

  initial begin
    logic [31:0] d;
    int          n;
    int          ph [2];
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    foreach (rst_regs[i]) rdc(rst_regs[i], 32'hffffffff, 32'h0);
    wr(9'h004, 32'hffffffff);
    rdc(9'h004, 32'hffffffff, 32'h0);
    d = $random(seed);
    wr(`REG_IRQ_MASK, d);
    rdc(`REG_IRQ_MASK, 32'hffffffff, d & 32'hf);
    wr(`REG_IRQ_MASK, 32'h0);
    repeat (60) @(posedge mclk);
    rdc(`REG_STATUS, 32'h3, 32'h3);
    wr(`REG_CLK_DIV, 32'h1);
    repeat (10) @(posedge mclk);
    rdc(`REG_STATUS, 32'h1, 32'h0);
    repeat (60) @(posedge mclk);
    rdc(`REG_STATUS, 32'h1, 32'h1);
    // locked at ratio 2: the internal clock is high in half of the sample clocks
    n = 0;
    repeat (8) begin
      @(posedge mclk);
      #1;
      n += internal_clk;
    end
    chk("duty", 32'h4, 32'(n));
    @(posedge mclk);
    wr(`REG_CLK_DIV, 32'h2);
    repeat (80) @(posedge mclk);
    rdc(`REG_STATUS, 32'h1, 32'h0);
    wr(`REG_CONFIG, 32'h1);
    rdc(`REG_STATUS, 32'h2, 32'h2);
    wr(`REG_CLK_DIV, 32'h0);
    rdc(`REG_STATUS, 32'h2, 32'h0);
    wr(`REG_CONFIG, 32'h0);
    stabilizer_strap <= 1'h0;
    rdc(`REG_STATUS, 32'h2, 32'h0);
    stabilizer_strap <= 1'h1;
    format_select_strap <= 1'h1;
    for (int i = 2; i < 9; i++) begin
      wr(`REG_CLK_DIV, 32'(i - 1));
      next_rise(n);
      next_rise(n);
      chk("period", 32'(i), 32'(n + 1));
    end
    wr(`REG_CLK_DIV, 32'h0);
    for (int f = 0; f < 4; f++) begin
      logic [1:0] fx;
      fx = f < 3 ? 2'(f) : 2'h1;
      wr(`REG_CONFIG, f < 3 ? 32'h9 | 32'(f << 1) : 32'h0);
      for (int k = 0; k < 50; k++) begin
        @(posedge mclk);
        hist.push_front({code(core_a, fx), code(core_b, fx)});
        core_a <= k < 16 ? corner[k % 8] : 12'($random(seed));
        core_b <= 12'($random(seed));
        #1;
        if (k > 14)
          chk("stream", {10'h0, hist[12]}, {10'h0, overrange_a, data_a, overrange_b, data_b});
      end
      @(posedge mclk);
    end
    wr(`REG_CLK_DIV, 32'h3);
    core_a <= 12'h100;
    repeat (60) @(posedge mclk);
    // straps still rule here and the format strap is high: twos complement
    chk("capture", 32'h080, {22'h0, cap_a});
    wr(`REG_CONFIG, 32'h19);
    repeat (60) @(posedge mclk);
    chk("capture", 32'h280, {22'h0, cap_a});
    wr(`REG_IRQ_MASK, 32'h1);
    wr(`REG_SYNC_CTRL, 32'h2);
    for (int i = 0; i < 2; i++) begin
      repeat (($random(seed) & 7) + 1) @(posedge mclk);
      pulse();
      next_rise(ph[i]);
    end
    chk("sync phase", 32'(ph[0]), 32'(ph[1]));
    irq_is(1'h1);
    rdc(`REG_IRQ_STATUS, 32'h1, 32'h1);
    irq_is(1'h0);
    wr(`REG_SYNC_CTRL, 32'h6);
    rdc(`REG_STATUS, 32'h10, 32'h10);
    pulse();
    rdc(`REG_STATUS, 32'h10, 32'h0);
    rdc(`REG_IRQ_STATUS, 32'h1, 32'h1);
    pulse();
    rdc(`REG_IRQ_STATUS, 32'h1, 32'h0);
    wr(`REG_IRQ_MASK, 32'h0);
    wr(`REG_SYNC_CTRL, 32'h2);
    pulse();
    repeat (2) @(posedge mclk);
    irq_is(1'h0);
    rdc(`REG_IRQ_STATUS, 32'h1, 32'h1);
    output_tristate_pin <= 1'h1;
    oe(3'h1);
    output_tristate_pin <= 1'h0;
    oe(3'h7);
    wr(`REG_OUT_DISABLE, 32'h1);
    oe(3'h3);
    wr(`REG_OUT_DISABLE, 32'h2);
    oe(3'h5);
    wr(`REG_OUT_DISABLE, 32'h0);
    power_down_pin <= 1'h1;
    oe(3'h0);
    rdc(`REG_STATUS, 32'h4, 32'h4);
    power_down_pin <= 1'h0;
    oe(3'h7);
    wr(`REG_CONFIG, 32'h29);
    oe(3'h0);
    wr(`REG_CONFIG, 32'h49);
    oe(3'h7);
    rdc(`REG_STATUS, 32'hc, 32'h8);
    conclude();
  end
endmodule // adc_ctrl_tb
